/* rtl/gcc_bank_top.sv */
`timescale 1ns/1ps
module gcc_bank_top import gcc_pkg::*; #(
    parameter int unsigned HOLD_UNIT = HOLD_UNIT_TCLK
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        link_sclk_i,
    input  wire logic        serial_enable_b_i,
    input  wire logic        serial_data_i,
    input  wire logic        curve_trigger_i,
    output logic             serial_data_o,
    output logic [8:0]       gain_eighths_o,
    output logic             curve_busy_o
);
    logic        wr_tgl;
    logic [7:0]  wr_addr;
    logic [15:0] wr_data;
    logic        rd_tgl;
    logic [7:0]  rd_addr;
    logic [8:0]  rd_word;
    logic [2:0]  wr_sync;
    logic [2:0]  rd_sync;
    logic [2:0]  trig_sync;
    logic        wr_ev;
    logic        rd_ev;
    logic        rd_ev_d;
    logic        trig_rise;
    logic        trig_pend;

    logic        curve_bank_select;
    logic        readout_en;
    logic [7:0]  first_ptr;
    logic [7:0]  last_ptr;
    logic [5:0]  init_gain;
    logic        eighth_db_interpolation;
    logic [7:0]  hold_reg;
    logic        soft_retrigger;
    logic        slope_mode;
    logic        fixed_gain_select;
    logic [2:0]  eighth_gain;
    logic [5:0]  whole_gain;
    logic [7:0]  slope_rate;

    logic        wr_ok;
    logic        curve_wr;
    logic        mem_we;
    logic [8:0]  entry;
    logic [8:0]  mem_rd_b;
    logic [8:0]  rd_mux;

    gcc_state_t  state;
    logic [3:0]  tick_cnt;
    logic        tick;
    logic [8:0]  gain;
    logic [7:0]  idx;
    logic [7:0]  ivl_cnt;
    logic [2:0]  sub;
    logic [13:0] hold_cnt;

    gcc_serial_port u_port (
        .rst_b_i   (rst_b_i),
        .sclk_i    (link_sclk_i),
        .sen_b_i   (serial_enable_b_i),
        .sdata_i   (serial_data_i),
        .rd_word_i (rd_word),
        .wr_tgl_o  (wr_tgl),
        .wr_addr_o (wr_addr),
        .wr_data_o (wr_data),
        .rd_tgl_o  (rd_tgl),
        .rd_addr_o (rd_addr),
        .sdout_o   (serial_data_o)
    );

    // Toggles and the trigger pin cross on two flops; the third only finds edges.
    // Address and data words are steady long before their toggle lands here.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_sync   <= '0;
            rd_sync   <= '0;
            trig_sync <= '0;
            rd_ev_d   <= 1'b0;
        end else begin
            wr_sync   <= {wr_sync[1:0], wr_tgl};
            rd_sync   <= {rd_sync[1:0], rd_tgl};
            trig_sync <= {trig_sync[1:0], curve_trigger_i};
            rd_ev_d   <= rd_ev;
        end
    end

    assign wr_ev     = wr_sync[2] ^ wr_sync[1];
    assign rd_ev     = rd_sync[2] ^ rd_sync[1];
    assign trig_rise = trig_sync[1] & ~trig_sync[2];

    // In readout mode frames are reads, but address 0 still writes
    // so that software can leave readout mode.
    assign wr_ok    = wr_ev && (!readout_en || wr_addr == ADDR_GP_CTRL);
    assign curve_wr = wr_ok && curve_bank_select && wr_addr != ADDR_GP_CTRL;
    assign mem_we   = curve_wr && wr_addr <= ADDR_TABLE_LAST;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            curve_bank_select <= 1'b0;
            readout_en        <= 1'b0;
        end else if (wr_ok && wr_addr == ADDR_GP_CTRL) begin
            curve_bank_select <= wr_data[BANK_SEL_BIT];
            readout_en        <= wr_data[READOUT_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_ptr               <= '0;
            last_ptr                <= '0;
            init_gain               <= '0;
            eighth_db_interpolation <= 1'b0;
            hold_reg                <= '0;
            soft_retrigger          <= 1'b0;
            slope_mode              <= 1'b0;
            fixed_gain_select       <= 1'b0;
            eighth_gain             <= '0;
            whole_gain              <= '0;
            slope_rate              <= '0;
        end else if (curve_wr) begin
            unique case (wr_addr)
                ADDR_FIRST_PTR: first_ptr <= wr_data[7:0];
                ADDR_LAST_PTR:  last_ptr  <= wr_data[7:0];
                ADDR_INIT_GAIN: begin
                    init_gain               <= wr_data[5:0];
                    eighth_db_interpolation <= wr_data[INTERP_BIT];
                end
                ADDR_HOLD:      hold_reg  <= wr_data[7:0];
                ADDR_MODE: begin
                    soft_retrigger    <= wr_data[SOFT_BIT];
                    slope_mode        <= wr_data[SLOPE_MODE_BIT];
                    fixed_gain_select <= wr_data[FIXED_BIT];
                    eighth_gain       <= wr_data[2:0];
                end
                ADDR_WHOLE_DB:  whole_gain <= wr_data[5:0];
                ADDR_SLOPE:     slope_rate <= wr_data[7:0];
                default: ;
            endcase
        end
    end

    gcc_step_mem #(
        .DEPTH (TABLE_DEPTH),
        .WIDTH (ENTRY_W)
    ) u_mem (
        .clk_i    (sys_clk_i),
        .rst_b_i  (rst_b_i),
        .we_i     (mem_we),
        .waddr_i  (wr_addr - 8'h01),
        .wdata_i  (wr_data[8:0]),
        .a_addr_i (idx - 8'h01),
        .a_data_o (entry),
        .b_addr_i (rd_addr - 8'h01),
        .b_data_o (mem_rd_b)
    );

    always_comb begin
        rd_mux = '0;
        if (rd_addr == ADDR_GP_CTRL) begin
            rd_mux = {6'h00, curve_bank_select, readout_en, 1'b0};
        end else if (curve_bank_select) begin
            if (rd_addr <= ADDR_TABLE_LAST) begin
                rd_mux = mem_rd_b;
            end else begin
                unique case (rd_addr)
                    ADDR_FIRST_PTR: rd_mux = {1'b0, first_ptr};
                    ADDR_LAST_PTR:  rd_mux = {1'b0, last_ptr};
                    ADDR_INIT_GAIN: rd_mux = {1'b0, ~eighth_db_interpolation,
                                              1'b0, init_gain};
                    ADDR_HOLD:      rd_mux = {1'b0, hold_reg};
                    ADDR_MODE:      rd_mux = {3'b000, soft_retrigger, slope_mode,
                                              fixed_gain_select, eighth_gain};
                    ADDR_WHOLE_DB:  rd_mux = {3'b000, whole_gain};
                    ADDR_SLOPE:     rd_mux = {1'b0, slope_rate};
                    default:        rd_mux = '0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_word <= '0;
        end else if (rd_ev_d) begin
            rd_word <= rd_mux;
        end
    end

    // Gain engine, paced by one tick per sample period.
    logic [8:0]  init_e;
    logic [8:0]  fixed_e;
    logic [8:0]  fixed_sum;
    logic [7:0]  step_src;
    logic [7:0]  n_eff;
    logic        ivl_done;
    logic        interp_eff;
    logic        down;
    logic        last_entry;
    logic        entry_end;
    logic [8:0]  step_amt;
    logic [9:0]  up_gain;
    logic        over;
    logic        start_now;
    logic [13:0] hold_load;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= (tick_cnt == TICK_LAST) ? 4'h0 : tick_cnt + 4'h1;
        end
    end
    assign tick = tick_cnt == TICK_LAST;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trig_pend <= 1'b0;
        end else if (trig_rise) begin
            trig_pend <= 1'b1;
        end else if (tick) begin
            trig_pend <= 1'b0;
        end
    end

    assign init_e  = {(init_gain > GAIN_CODE_MAX) ? GAIN_CODE_MAX : init_gain, 3'h0};
    assign fixed_sum = {(whole_gain > GAIN_CODE_MAX) ? GAIN_CODE_MAX : whole_gain, 3'h0}
                       + {6'h00, eighth_gain};
    assign fixed_e   = (fixed_sum > GAIN_MAX_E) ? GAIN_MAX_E : fixed_sum;
    assign step_src   = slope_mode ? slope_rate : entry[7:0];
    assign n_eff      = (step_src == 8'h00) ? 8'h01 : step_src;
    assign ivl_done   = ivl_cnt == n_eff - 8'h01;
    assign interp_eff = eighth_db_interpolation | slope_mode;
    assign down       = !slope_mode && entry[DIR_BIT];
    assign last_entry = !slope_mode && (idx == last_ptr || idx == 8'(TABLE_DEPTH));
    // The last entry stops one interval short, which yields the 0.875 dB
    // lead with interpolation and a frozen last step without it.
    assign entry_end  = !slope_mode && ivl_done
                        && (last_entry ? sub == 3'h6 : sub == 3'h7);
    assign step_amt   = interp_eff ? 9'h001
                        : ((sub == 3'h7 && !last_entry) ? DB_STEP_E : 9'h000);
    assign up_gain    = {1'b0, gain} + {1'b0, step_amt};
    assign over       = down ? (gain < step_amt) : (up_gain > {1'b0, GAIN_MAX_E});
    assign start_now  = tick && (trig_pend || (soft_retrigger && state == GCC_IDLE));
    assign hold_load  = 14'(hold_reg * HOLD_UNIT);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state    <= GCC_IDLE;
            gain     <= '0;
            idx      <= '0;
            ivl_cnt  <= '0;
            sub      <= '0;
            hold_cnt <= '0;
        end else if (fixed_gain_select) begin
            state <= GCC_IDLE;
            gain  <= fixed_e;
        end else if (start_now) begin
            state   <= GCC_RAMP;
            gain    <= init_e;
            idx     <= first_ptr;
            ivl_cnt <= '0;
            sub     <= '0;
        end else if (tick) begin
            unique case (state)
                GCC_IDLE: ;
                GCC_RAMP: begin
                    if (!ivl_done) begin
                        ivl_cnt <= ivl_cnt + 8'h01;
                    end else if (over || entry_end && last_entry) begin
                        if (!over) begin
                            gain <= down ? gain - step_amt : up_gain[8:0];
                        end
                        hold_cnt <= hold_load;
                        state    <= (hold_reg == 8'h00) ? GCC_RETURN : GCC_HOLD;
                    end else begin
                        gain    <= down ? gain - step_amt : up_gain[8:0];
                        ivl_cnt <= '0;
                        sub     <= sub + 3'h1;
                        if (entry_end) begin
                            idx <= idx + 8'h01;
                            sub <= '0;
                        end
                    end
                end
                GCC_HOLD: begin
                    hold_cnt <= hold_cnt - 14'h0001;
                    if (hold_cnt == 14'h0001) begin
                        state <= GCC_RETURN;
                    end
                end
                GCC_RETURN: begin
                    if (gain == init_e) begin
                        state <= GCC_IDLE;
                    end else if (gain > init_e) begin
                        gain <= (gain - init_e > DB_STEP_E) ? gain - DB_STEP_E : init_e;
                    end else begin
                        gain <= (init_e - gain > DB_STEP_E) ? gain + DB_STEP_E : init_e;
                    end
                end
            endcase
        end
    end

    assign gain_eighths_o = gain;
    assign curve_busy_o   = state != GCC_IDLE;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_start;
        start_now && !fixed_gain_select;
    endsequence

    sequence s_return_big;
        state == GCC_RETURN && tick && !fixed_gain_select && !trig_pend
            && gain > init_e + DB_STEP_E;
    endsequence

    sequence s_frozen;
        state == GCC_RAMP && !interp_eff && !fixed_gain_select && !start_now
            && !(tick && ivl_done);
    endsequence

    chk_bank_write: assert property (
        wr_ok && wr_addr == ADDR_GP_CTRL |=> curve_bank_select == $past(wr_data[BANK_SEL_BIT]))
        else $error("bank select did not follow a write to address 0");

    chk_table_range: assert property (
        mem_we |-> wr_addr >= ADDR_TABLE_FIRST && wr_addr <= ADDR_TABLE_LAST && curve_bank_select)
        else $error("table write outside the curve entry range");

    chk_gain_limit: assert property (
        gain <= GAIN_MAX_E)
        else $error("working gain above the upper limit");

    chk_interp_readback: assert property (
        rd_ev_d && curve_bank_select && rd_addr == ADDR_INIT_GAIN
            |=> rd_word[INTERP_BIT] == !$past(eighth_db_interpolation))
        else $error("interpolation bit not inverted on read");

    chk_return_step: assert property (
        s_return_big |=> gain == $past(gain) - DB_STEP_E)
        else $error("return ramp did not move by 1 dB");

    chk_hold_load: assert property (
        $rose(state == GCC_HOLD) |-> hold_cnt == 14'(hold_reg * HOLD_UNIT))
        else $error("hold count not loaded from the hold register");

    chk_fixed_gain: assert property (
        fixed_gain_select && $past(fixed_gain_select)
            |=> gain == $past(fixed_e) && state == GCC_IDLE)
        else $error("fixed gain not applied");

    chk_trigger_start: assert property (
        s_start |=> state == GCC_RAMP && gain == $past(init_e) && idx == $past(first_ptr))
        else $error("curve start did not load initial gain and first pointer");

    chk_tick_pace: assert property (
        tick |=> !tick ##1 tick)
        else $error("sample tick not every second input clock");

    chk_step_frozen: assert property (
        s_frozen |=> gain == $past(gain))
        else $error("gain moved between 1 dB steps without interpolation");
endmodule // gcc_bank_top

/* shared/gcc_pkg.sv */
package gcc_pkg;
// Notes on behaviour
// - Register 0 bit 2 selects curve bank when 1, general bank when 0; resets 0.
// - Register 0 answers at address 0 in either bank.
// - Curve bank registers start at address 1; none sits at address 0.
// - 148 step entries of 9 bits live at curve addresses 0x01 to 0x94.
// - Entry bit 8 gives step direction: 0 raises gain, 1 lowers it.
// - Entry bits 7:0 give 1 dB duration in 8-sample units; 0x00 means 8 samples.
// - Gain steps are paced by the sample period, two input clock periods.
// - Initial gain field means -5 dB plus value; 0x24 is 31 dB.
// - Final gain is computed by stepping, with extra 0.875 dB when interpolating.
// - Final gain holds for count times 33 sample periods; zero gives none.
// - After the hold the gain returns to initial gain 1 dB per sample period.
// - Interpolating, gain moves 0.125 dB every N samples; 0 and 1 mean one.
// - Not interpolating, gain moves 1 dB every 8N samples; 0 and 1 mean 8.
// - Reading address 0x97 shows the interpolation bit inverted.
// - Self-retrigger bit reruns the curve without any trigger pin pulse.
// - Linear-slope bit 0 follows the table; 1 ramps up at the slope rate.
// - Fixed-gain bit stops the engine; gain is whole plus eighth setting.
// - Whole-dB field means -5 dB plus value; above 0x24 acts as 0x24.
// - Eighth-dB field adds its value times 0.125 dB to the fixed gain, which stops at 31 dB.
// - Trigger pulse loads initial gain and starts stepping at the first pointer.
// - Stepping ends after the last entry or when gain would pass a limit.

    localparam int SYS_CLK_PERIOD_NS = 40;
    localparam int SAMPLE_PERIOD_NS  = 2 * SYS_CLK_PERIOD_NS;
    localparam int TICK_CYCLES       = SAMPLE_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam logic [3:0] TICK_LAST = 4'(TICK_CYCLES - 1);

    localparam int TABLE_DEPTH = 148;
    localparam int ENTRY_W     = 9;
    localparam int HOLD_UNIT_TCLK = 33;

    localparam logic [7:0] ADDR_GP_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_TABLE_FIRST = 8'h01;
    localparam logic [7:0] ADDR_TABLE_LAST  = 8'h94;
    localparam logic [7:0] ADDR_FIRST_PTR   = 8'h95;
    localparam logic [7:0] ADDR_LAST_PTR    = 8'h96;
    localparam logic [7:0] ADDR_INIT_GAIN   = 8'h97;
    localparam logic [7:0] ADDR_HOLD        = 8'h98;
    localparam logic [7:0] ADDR_MODE        = 8'h99;
    localparam logic [7:0] ADDR_WHOLE_DB    = 8'h9a;
    localparam logic [7:0] ADDR_SLOPE       = 8'h9b;

    localparam int BANK_SEL_BIT   = 2;
    localparam int READOUT_BIT    = 1;
    localparam int INTERP_BIT     = 7;
    localparam int SOFT_BIT       = 5;
    localparam int SLOPE_MODE_BIT = 4;
    localparam int FIXED_BIT      = 3;
    localparam int DIR_BIT        = 8;

    localparam logic [5:0] GAIN_CODE_MAX = 6'h24;
    localparam logic [8:0] GAIN_MAX_E    = 9'h120;
    localparam logic [8:0] DB_STEP_E     = 9'h008;

    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] ADDR_LAST  = 5'h07;
    localparam logic [4:0] DOUT_FIRST = 5'h0f;

    typedef enum logic [1:0] {
        GCC_IDLE,
        GCC_RAMP,
        GCC_HOLD,
        GCC_RETURN
    } gcc_state_t;
endpackage

/* rtl/gcc_step_mem.sv */
`timescale 1ns/1ps
module gcc_step_mem #(
    parameter int DEPTH = 148,
    parameter int WIDTH = 9
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             we_i,
    input  wire logic [7:0]       waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [7:0]       a_addr_i,
    output logic      [WIDTH-1:0] a_data_o,
    input  wire logic [7:0]       b_addr_i,
    output logic      [WIDTH-1:0] b_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i && (int'(waddr_i) < DEPTH)) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Out-of-range indices read as zero rather than aliasing.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            a_data_o <= '0;
            b_data_o <= '0;
        end else begin
            a_data_o <= (int'(a_addr_i) < DEPTH) ? mem[a_addr_i] : '0;
            b_data_o <= (int'(b_addr_i) < DEPTH) ? mem[b_addr_i] : '0;
        end
    end
endmodule // gcc_step_mem

/* rtl/gcc_serial_port.sv */
`timescale 1ns/1ps
module gcc_serial_port import gcc_pkg::*; (
    input  wire logic        rst_b_i,
    input  wire logic        sclk_i,
    input  wire logic        sen_b_i,
    input  wire logic        sdata_i,
    input  wire logic [8:0]  rd_word_i,
    output logic             wr_tgl_o,
    output logic [7:0]       wr_addr_o,
    output logic [15:0]      wr_data_o,
    output logic             rd_tgl_o,
    output logic [7:0]       rd_addr_o,
    output logic             sdout_o
);
    logic [4:0]  cnt;
    logic [22:0] shift;

    // The frame enable clears the bit count, so a stopped clock leaves no stale frame.
    always_ff @(posedge sclk_i or posedge sen_b_i or negedge rst_b_i) begin
        if (!rst_b_i || sen_b_i) begin
            cnt <= '0;
        end else if (cnt != FRAME_LAST + 5'h01) begin
            cnt <= cnt + 5'h01;
        end
    end

    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift     <= '0;
            wr_tgl_o  <= 1'b0;
            wr_addr_o <= '0;
            wr_data_o <= '0;
            rd_tgl_o  <= 1'b0;
            rd_addr_o <= '0;
        end else begin
            shift <= {shift[21:0], sdata_i};
            if (cnt == ADDR_LAST) begin
                rd_addr_o <= {shift[6:0], sdata_i};
                rd_tgl_o  <= ~rd_tgl_o;
            end
            // Only a full 24-bit frame writes; a cut frame is dropped.
            if (cnt == FRAME_LAST) begin
                wr_addr_o <= shift[22:15];
                wr_data_o <= {shift[14:0], sdata_i};
                wr_tgl_o  <= ~wr_tgl_o;
            end
        end
    end

    // Data bits 15 to 9 are always zero, which gives the system side
    // seven serial periods to answer the address before bit 8 is due.
    always_ff @(negedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sdout_o <= 1'b0;
        end else if (cnt >= DOUT_FIRST && cnt <= FRAME_LAST) begin
            sdout_o <= rd_word_i[4'(FRAME_LAST - cnt)];
        end else begin
            sdout_o <= 1'b0;
        end
    end
endmodule // gcc_serial_port

/* sim/gcc_ctl_model.sv */
`timescale 1ns/1ps
module gcc_ctl_model (
    output logic      sclk_o,
    output logic      sen_b_o,
    output logic      sdata_o,
    input  wire logic sdout_i
);
    initial begin
        sclk_o  = 1'b0;
        sen_b_o = 1'b1;
        sdata_o = 1'b1;
    end
    // The serial clock runs only inside a frame and stays low between frames.
    task automatic xfer(input logic [7:0] addr, input logic [15:0] data,
                        output logic [15:0] rd);
        logic [23:0] word;
        word = {addr, data};
        #17;
        sen_b_o = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdata_o = word[i];
            #40 sclk_o = 1'b1;
            if (i < 16) rd[i] = sdout_i;
            #40 sclk_o = 1'b0;
        end
        sen_b_o = 1'b1;
        // A released line shows the inverse so a stale value is never mistaken for data.
        sdata_o = ~word[0];
        #400;
    endtask
endmodule // gcc_ctl_model

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import gcc_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        trig = 1'b0;
    logic        sclk, sen_b, sdi, sdo, busy;
    logic [8:0]  gain;
    logic [15:0] rd;
    int          num_errors = 0;
    int          checks = 0;
    int          n;
    always #20 sys_clk_i = ~sys_clk_i;
    gcc_bank_top #(.HOLD_UNIT(2)) i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .link_sclk_i(sclk), .serial_enable_b_i(sen_b), .serial_data_i(sdi),
        .curve_trigger_i(trig), .serial_data_o(sdo), .gain_eighths_o(gain),
        .curve_busy_o(busy));
    gcc_ctl_model i_ctl (.sclk_o(sclk), .sen_b_o(sen_b), .sdata_o(sdi), .sdout_i(sdo));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_ctl.xfer(a, d, rd);
    endtask
    task automatic wait_gain(input logic [8:0] v, input string what);
        for (int i = 0; i < 3000 && gain !== v; i++) @(negedge sys_clk_i);
        chk(what, {7'h00, v}, {7'h00, gain});
        for (n = 0; n < 3000 && gain === v; n++) @(negedge sys_clk_i);
    endtask
    task automatic wait_busy(input logic v, input string what);
        for (int i = 0; i < 3000 && busy !== v; i++) @(negedge sys_clk_i);
        chk(what, {15'h0, v}, {15'h0, busy});
    endtask
    task automatic pulse();
        @(negedge sys_clk_i) trig = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        trig = 1'b0;
    endtask
    task automatic t_readback();
        wr(8'h00, 16'h0002);
        i_ctl.xfer(8'h00, 16'h0002, rd);
        chk("reg0", 16'h0002, rd);
        i_ctl.xfer(8'h97, 16'h0000, rd);
        chk("gp 0x97", 16'h0000, rd);
        wr(8'h00, 16'h0006);
        i_ctl.xfer(8'h00, 16'h0006, rd);
        chk("reg0 bank1", 16'h0006, rd);
        i_ctl.xfer(8'h97, 16'h0000, rd);
        chk("0x97 reset", 16'h0080, rd);
        wr(8'h00, 16'h0004);
        wr(8'h97, 16'h0085);
        wr(8'h00, 16'h0006);
        i_ctl.xfer(8'h97, 16'h0000, rd);
        chk("0x97 interp", 16'h0005, rd);
        wr(8'h00, 16'h0004);
    endtask
    task automatic t_fixed();
        wr(8'h9a, 16'h0030);
        wr(8'h99, 16'h000f);
        chk("whole clamp", 16'd288, {7'h00, gain});
        wr(8'h9a, 16'h0010);
        wr(8'h99, 16'h000b);
        chk("fixed gain", 16'd131, {7'h00, gain});
        pulse();
        repeat (10) @(negedge sys_clk_i);
        chk("fixed idle", 16'h0000, {15'h0, busy});
        wr(8'h99, 16'h0000);
    endtask
    task automatic t_curve(input logic [7:0] g, input logic [15:0] e, input int dw,
                           input logic [8:0] fin, input int hd);
        wr(8'h01, e);
        wr(8'h02, 16'h0000);
        wr(8'h95, 16'h0001);
        wr(8'h96, 16'h0002);
        wr(8'h98, 16'h0001);
        wr(8'h97, {8'h00, g});
        pulse();
        wait_busy(1'b1, "curve start");
        wait_gain(9'd48, "start gain");
        chk("dwell", 16'(dw), 16'(n));
        wait_gain(fin, "final gain");
        chk("hold", 16'(hd), 16'(n));
        wait_gain(9'd48, "return gain");
        wait_busy(1'b0, "curve done");
    endtask
    task automatic t_slope();
        wr(8'h9b, 16'h0001);
        wr(8'h99, 16'h0010);
        pulse();
        wait_busy(1'b1, "slope start");
        wait_gain(9'd48, "slope initial");
        chk("slope rate", 16'd2, 16'(n));
        wait_gain(9'd288, "slope limit");
        chk("slope hold", 16'd8, 16'(n));
        wait_busy(1'b0, "slope done");
    endtask
    task automatic t_soft();
        wr(8'h99, 16'h0020);
        wait_busy(1'b1, "self retrigger");
        wr(8'h99, 16'h0000);
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        chk("reset gain", 16'h0000, {7'h00, gain});
        t_readback();
        t_fixed();
        t_curve(8'h06, 16'h0000, 16, 9'd56, 20);
        t_curve(8'h86, 16'h0002, 4, 9'd63, 6);
        t_slope();
        t_soft();
        print_verdict();
    end
    initial begin
        #3000000;
        num_errors++;
        print_verdict();
    end
endmodule // testbench
